// ---- hw/mme_pkg.sv ----
`default_nettype none
package mme_pkg;
	// Monitor mode selection
	typedef enum logic [1:0] {
		MME_USER,
		MME_NORMAL,
		MME_FORCED_EXT,
		MME_FORCED_INT
	} mme_mode_type;
	// Serial shell states
	typedef enum logic [2:0] {
		MME_S_IDLE,
		MME_S_RX,
		MME_S_BRK_WAIT,
		MME_S_BRK_TX,
		MME_S_READY
	} mme_ser_type;
	// Bus clock and bit periods
	localparam int MME_BIT_EXT_CLKS = 256;
	localparam int MME_BIT_INT_CLKS = 335;
	localparam logic [8:0] MME_BIT_EXT_M1 = 9'(MME_BIT_EXT_CLKS - 1);
	localparam logic [8:0] MME_BIT_INT_M1 = 9'(MME_BIT_INT_CLKS - 1);
	// Frame sizes
	localparam logic [3:0] MME_FRAME_BITS = 4'hA;
	localparam logic [3:0] MME_BREAK_BITS = 4'hA;
	localparam logic [3:0] MME_SEC_BYTES = 4'h8;
	localparam logic [3:0] MME_BRK_GAP_BITS = 4'h2;
	// Vector page values
	localparam logic [7:0] MME_USER_VEC_PAGE = 8'hFF;
	localparam logic [7:0] MME_MON_VEC_PAGE = 8'hFE;
	localparam logic [7:0] MME_ERASED_BYTE = 8'hFF;
	// Reset values
	localparam logic [1:0] MME_MODE_RST = 2'h0;
endpackage
`default_nettype wire

// ---- hw/mme_bit_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
// Bit period tick generator for the monitor serial line
module mme_bit_timer (
	input wire logic clk, // Bus clock
	input wire logic rst, // Synchronous reset, restarts count
	input wire logic restart, // Restart at start of bit
	input wire logic use_int, // Internal oscillator period
	output logic half_tick, // Middle of a bit
	output logic bit_tick // End of a bit
);
	logic [8:0] cnt_q; // Cycle counter within a bit
	logic [8:0] cnt_d;
	wire logic [8:0] last_w = use_int ? mme_pkg::MME_BIT_INT_M1 : mme_pkg::MME_BIT_EXT_M1;
	wire logic at_end_w = (cnt_q == last_w);

	// Count wraps every bit period
	assign cnt_d = (restart || at_end_w) ? 9'h000 : cnt_q + 9'h001;
	assign bit_tick = at_end_w && !restart;
	assign half_tick = (cnt_q == {1'b0, last_w[8:1]}) && !restart;

	// Counter register
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= 9'h000;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // mme_bit_timer
`default_nettype wire

// ---- hw/mme_entry_ctrl.sv ----
// What this block does
// - Monitor traffic uses only the serial pin
// - Serial pin only pulled low or released
// - Low interrupt pin, erased vector: internal trimmed oscillator
// - Internal-oscillator option blocked when vector programmed
// - Normal entry: high voltage, serial 1, selects 1/0
// - Forced entry clock chosen by interrupt pin level
// - Mode captured when internal reset is released (falling edge)
// - Select pins ignored after mode captured
// - Wait for eight security bytes first
// - Then send break of ten zero bits
// - Normal mode: reset, clock on alternate pins
// - Voltage removed: stay monitor, freeze pin config
// - Voltage removed: branch sampling needs pin enable
// - Watchdog off while high voltage stays present
// - Forced entry skips mode-select pin checks
// - Erased fetched vector triggers reset into forced
// - Forced mode always disables the watchdog
// - Forced, pin high: inputs except serial, clock
// - Forced, pin low: inputs except serial
// - Monitor mode: port bit two reads zero
// - Forced mode: branch instructions treat pin enabled
// - Non power-on resets return to forced monitor
// - Bit period 256 or 335 bus clocks
// - NRZ frames, equal rates both ways
// - Monitor vectors fetched from page below user
`timescale 1ns/1ns
`default_nettype none
module mme_entry_ctrl (
	input wire logic MCLK, // Bus clock
	input wire logic SYS_RST, // Synchronous reset, active high
	input wire logic POR_PULSE, // Power-on reset indication, same domain
	input wire logic INT_RESET, // Internal reset level, same domain
	input wire logic TEST_HIGH_VOLTAGE, // High voltage detect on interrupt pin
	input wire logic INT_PIN_LEVEL, // Interrupt pin logic level
	input wire logic MODE_SELECT_LOW_PIN, // Mode select 0 pin
	input wire logic MODE_SELECT_HIGH_PIN, // Mode select 1 pin
	input wire logic MONITOR_SERIAL_PIN_IN, // Serial pin level
	output logic MONITOR_SERIAL_PIN_OUT, // Serial pin output value, always low
	output logic MONITOR_SERIAL_PIN_OE_N, // Serial pin drive, low drives
	input wire logic RESET_VECTOR_ERASED, // Reset vector reads as blank
	input wire logic VEC_FETCH_VALID, // Reset vector byte fetch strobe
	input wire logic [7:0] VEC_FETCH_DATA, // Fetched vector byte
	input wire logic INT_PIN_FUNCTION_ENABLE, // Config enable for interrupt pin
	input wire logic CFG_ALT_RESET_EN, // Config reset function on alt pin
	input wire logic CFG_ALT_CLOCK_EN, // Config clock function on alt pin
	input wire logic SEC_BYTE_DONE, // Firmware finished one security byte
	input wire logic PORT_INT_BIT_RAW, // Raw port data bit two
	output logic MONITOR_ACTIVE, // Monitor mode latched
	output logic FORCED_MONITOR, // Forced monitor latched
	output logic USE_INTERNAL_OSC, // Internal oscillator selected
	output logic APPLY_OSC_TRIM, // Apply stored trim value
	output logic EXT_CLOCK_SELECT, // External clock input selected
	output logic WATCHDOG_DISABLE, // Watchdog timer held off
	output logic ALT_RESET_PIN_EN, // Reset function on alt reset pin
	output logic ALT_CLOCK_IN_PIN_EN, // Clock function on alt clock pin
	output logic PINS_FORCE_INPUT, // Other pins default to inputs
	output logic BRANCH_INT_ENABLE, // Branch instructions sample pin
	output logic PORT_INT_BIT_READ, // Port data bit two as read
	output logic [7:0] VECTOR_PAGE, // Page for reset, break, swi vectors
	output logic VECTOR_RESET_REQ, // Request internal reset for erased vector
	output logic MONITOR_READY // Break sent, ready for command
);
	// Pin inputs, two flip-flop synchronisers
	logic [1:0] hv_s_q; // High voltage detect
	logic [1:0] irq_s_q; // Interrupt pin level
	logic [1:0] ms0_s_q; // Mode select 0
	logic [1:0] ms1_s_q; // Mode select 1
	logic [1:0] ser_s_q; // Serial pin

	// Synchroniser chains
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			hv_s_q <= 2'h0;
			irq_s_q <= 2'h3;
			ms0_s_q <= 2'h0;
			ms1_s_q <= 2'h0;
			ser_s_q <= 2'h3;
		end else begin
			hv_s_q <= {hv_s_q[0], TEST_HIGH_VOLTAGE};
			irq_s_q <= {irq_s_q[0], INT_PIN_LEVEL};
			ms0_s_q <= {ms0_s_q[0], MODE_SELECT_LOW_PIN};
			ms1_s_q <= {ms1_s_q[0], MODE_SELECT_HIGH_PIN};
			ser_s_q <= {ser_s_q[0], MONITOR_SERIAL_PIN_IN};
		end
	end

	wire logic hv_w = hv_s_q[1]; // Synchronised high voltage
	wire logic irq_w = irq_s_q[1]; // Synchronised interrupt level
	wire logic ser_w = ser_s_q[1]; // Synchronised serial level

	// Mode decision combinational
	wire logic normal_ok_w = hv_w && ser_w && ms0_s_q[1] && !ms1_s_q[1];
	// Forced entry ignores mode selects; blank vector required
	wire logic forced_ok_w = !hv_w && RESET_VECTOR_ERASED;
	wire mme_pkg::mme_mode_type forced_sel_w = irq_w ? mme_pkg::MME_FORCED_EXT
		: mme_pkg::MME_FORCED_INT;
	wire mme_pkg::mme_mode_type pick_w = normal_ok_w ? mme_pkg::MME_NORMAL
		: (forced_ok_w ? forced_sel_w : mme_pkg::MME_USER);

	// Internal reset edge and sticky forced memory
	logic int_rst_q; // Previous internal reset level
	mme_pkg::mme_mode_type mode_q; // Latched mode
	mme_pkg::mme_mode_type mode_d;
	logic forced_mem_q; // Forced entry remembered across warm resets
	logic forced_mem_d;
	wire logic rise_w = int_rst_q && !INT_RESET; // Release of internal reset
	wire logic mode_fm_w = (mode_q == mme_pkg::MME_FORCED_EXT) ||
		(mode_q == mme_pkg::MME_FORCED_INT);
	// Warm reset keeps the earlier forced choice
	assign mode_d = POR_PULSE ? mme_pkg::mme_mode_type'(mme_pkg::MME_MODE_RST)
		: (rise_w ? ((forced_mem_q && mode_fm_w) ? mode_q : pick_w)
		: mode_q);
	assign forced_mem_d = POR_PULSE ? 1'b0
		: (forced_mem_q || (rise_w && (pick_w == mme_pkg::MME_FORCED_EXT
		|| pick_w == mme_pkg::MME_FORCED_INT)));

	// Mode latch
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			int_rst_q <= 1'b0; // Idle level, so no false release edge after reset
			mode_q <= mme_pkg::mme_mode_type'(mme_pkg::MME_MODE_RST);
			forced_mem_q <= 1'b0;
		end else begin
			int_rst_q <= INT_RESET;
			mode_q <= mode_d;
			forced_mem_q <= forced_mem_d;
		end
	end

	wire logic mon_w = (mode_q != mme_pkg::MME_USER); // Any monitor mode
	wire logic forced_w = mode_fm_w; // Forced monitor
	wire logic normal_w = (mode_q == mme_pkg::MME_NORMAL); // Normal monitor
	wire logic int_osc_w = (mode_q == mme_pkg::MME_FORCED_INT);

	// Erased vector watch in user mode
	logic vec_seen_q; // First erased byte of pair seen
	logic vec_req_q; // Reset request to reset logic
	wire logic vec_erased_w = VEC_FETCH_VALID && (VEC_FETCH_DATA == mme_pkg::MME_ERASED_BYTE);
	wire logic user_run_w = !mon_w && !INT_RESET && !hv_w;
	always_ff @(posedge MCLK) begin
		if (SYS_RST || INT_RESET) begin
			vec_seen_q <= 1'b0;
			vec_req_q <= 1'b0;
		end else if (user_run_w && VEC_FETCH_VALID) begin
			vec_seen_q <= vec_erased_w;
			vec_req_q <= vec_seen_q && vec_erased_w;
		end
	end

	// Pin config frozen when high voltage drops
	logic hv_prev_q; // Previous high voltage level
	logic frz_rst_q; // Frozen reset pin config
	logic frz_clk_q; // Frozen clock pin config
	logic hv_gone_q; // High voltage has dropped since entry
	always_ff @(posedge MCLK) begin
		if (SYS_RST || rise_w) begin
			hv_prev_q <= 1'b0;
			hv_gone_q <= 1'b0;
			frz_rst_q <= 1'b0;
			frz_clk_q <= 1'b0;
		end else begin
			hv_prev_q <= hv_w;
			if (hv_prev_q && !hv_w) begin
				hv_gone_q <= 1'b1;
				frz_rst_q <= CFG_ALT_RESET_EN;
				frz_clk_q <= CFG_ALT_CLOCK_EN;
			end
		end
	end

	wire logic hv_on_w = hv_w && !hv_gone_q; // High voltage still present
	wire logic alt_rst_w = normal_w ? (hv_on_w ? 1'b1 : frz_rst_q) : CFG_ALT_RESET_EN;
	wire logic alt_clk_w = normal_w ? (hv_on_w ? 1'b1 : frz_clk_q)
		: (mode_q == mme_pkg::MME_FORCED_EXT ? 1'b1 : CFG_ALT_CLOCK_EN);
	wire logic wdog_off_w = forced_w || (normal_w && hv_on_w);
	wire logic br_en_w = forced_w ? 1'b1 : INT_PIN_FUNCTION_ENABLE;
	wire logic port_bit_w = mon_w ? 1'b0 : PORT_INT_BIT_RAW;

	// Serial shell: count security bytes, then send break
	mme_pkg::mme_ser_type ser_q; // Serial state
	mme_pkg::mme_ser_type ser_d;
	logic [3:0] cnt_q; // Byte or bit counter
	logic [3:0] cnt_d;
	logic drive_low_q; // Pull serial line low
	logic drive_low_d;
	logic half_tick; // Timer middle of bit
	logic bit_tick; // Timer end of bit
	wire logic tmr_restart_w = (ser_q == mme_pkg::MME_S_IDLE);

	// Bit timing for break transmission
	mme_bit_timer u_bit_timer (
		.clk(MCLK),
		.rst(SYS_RST),
		.restart(tmr_restart_w),
		.use_int(int_osc_w),
		.half_tick(half_tick),
		.bit_tick(bit_tick)
	);

	// Next state of serial shell
	always_comb begin
		ser_d = ser_q;
		cnt_d = cnt_q;
		drive_low_d = 1'b0;
		case (ser_q)
			mme_pkg::MME_S_IDLE: begin
				cnt_d = 4'h0;
				if (mon_w && !INT_RESET) begin
					ser_d = mme_pkg::MME_S_RX;
				end
			end
			mme_pkg::MME_S_RX: begin
				if (SEC_BYTE_DONE) begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == mme_pkg::MME_SEC_BYTES - 4'h1) begin
						ser_d = mme_pkg::MME_S_BRK_WAIT;
						cnt_d = 4'h0;
					end
				end
			end
			mme_pkg::MME_S_BRK_WAIT: begin
				if (bit_tick) begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == mme_pkg::MME_BRK_GAP_BITS - 4'h1) begin
						ser_d = mme_pkg::MME_S_BRK_TX;
						cnt_d = 4'h0;
					end
				end
			end
			mme_pkg::MME_S_BRK_TX: begin
				drive_low_d = 1'b1;
				if (bit_tick) begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == mme_pkg::MME_BREAK_BITS - 4'h1) begin
						ser_d = mme_pkg::MME_S_READY; // Last low cycle still driven
					end
				end
			end
			default: begin
				ser_d = mme_pkg::MME_S_READY;
			end
		endcase
		if (INT_RESET || !mon_w) begin
			ser_d = mme_pkg::MME_S_IDLE;
			drive_low_d = 1'b0;
		end
	end

	// Serial shell registers
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			ser_q <= mme_pkg::MME_S_IDLE;
			cnt_q <= 4'h0;
			drive_low_q <= 1'b0;
		end else begin
			ser_q <= ser_d;
			cnt_q <= cnt_d;
			drive_low_q <= drive_low_d;
		end
	end

	// Output registers
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			MONITOR_SERIAL_PIN_OE_N <= 1'b1;
			MONITOR_ACTIVE <= 1'b0;
			FORCED_MONITOR <= 1'b0;
			USE_INTERNAL_OSC <= 1'b0;
			APPLY_OSC_TRIM <= 1'b0;
			EXT_CLOCK_SELECT <= 1'b0;
			WATCHDOG_DISABLE <= 1'b0;
			ALT_RESET_PIN_EN <= 1'b0;
			ALT_CLOCK_IN_PIN_EN <= 1'b0;
			PINS_FORCE_INPUT <= 1'b0;
			BRANCH_INT_ENABLE <= 1'b0;
			PORT_INT_BIT_READ <= 1'b0;
			VECTOR_PAGE <= mme_pkg::MME_USER_VEC_PAGE;
			VECTOR_RESET_REQ <= 1'b0;
			MONITOR_READY <= 1'b0;
		end else begin
			MONITOR_SERIAL_PIN_OE_N <= !drive_low_d;
			MONITOR_ACTIVE <= mon_w;
			FORCED_MONITOR <= forced_w;
			USE_INTERNAL_OSC <= int_osc_w;
			APPLY_OSC_TRIM <= int_osc_w;
			EXT_CLOCK_SELECT <= !int_osc_w;
			WATCHDOG_DISABLE <= wdog_off_w;
			ALT_RESET_PIN_EN <= alt_rst_w;
			ALT_CLOCK_IN_PIN_EN <= alt_clk_w;
			PINS_FORCE_INPUT <= forced_w;
			BRANCH_INT_ENABLE <= br_en_w;
			PORT_INT_BIT_READ <= port_bit_w;
			VECTOR_PAGE <= mon_w ? mme_pkg::MME_MON_VEC_PAGE : mme_pkg::MME_USER_VEC_PAGE;
			VECTOR_RESET_REQ <= vec_req_q;
			MONITOR_READY <= (ser_q == mme_pkg::MME_S_READY) && mon_w;
		end
	end

	// Serial output value is constant low; only the enable moves
	always_ff @(posedge MCLK) begin
		MONITOR_SERIAL_PIN_OUT <= 1'b0;
	end

	// Assertions
	property p_hold_mode;
		@(posedge MCLK) disable iff (SYS_RST)
		(!rise_w && !POR_PULSE) |=> (mode_q == $past(mode_q));
	endproperty
	a_hold_mode: assert property (p_hold_mode) else $error("Mode changed without reset edge");

	property p_wdog_forced;
		@(posedge MCLK) disable iff (SYS_RST)
		forced_w |=> WATCHDOG_DISABLE;
	endproperty
	a_wdog_forced: assert property (p_wdog_forced) else $error("Watchdog on in forced mode");

	property p_port_zero;
		@(posedge MCLK) disable iff (SYS_RST)
		mon_w |=> !PORT_INT_BIT_READ;
	endproperty
	a_port_zero: assert property (p_port_zero) else $error("Port bit two nonzero in monitor");

	property p_branch_forced;
		@(posedge MCLK) disable iff (SYS_RST)
		forced_w |=> BRANCH_INT_ENABLE;
	endproperty
	a_branch_forced: assert property (p_branch_forced) else $error("Branch pin not enabled");

	property p_no_int_osc_prog;
		@(posedge MCLK) disable iff (SYS_RST)
		(rise_w && !RESET_VECTOR_ERASED && !forced_mem_q) |=> (mode_q != mme_pkg::MME_FORCED_INT);
	endproperty
	a_no_int_osc_prog: assert property (p_no_int_osc_prog) else $error("Internal osc with programmed vector");

	property p_break_after_sec;
		@(posedge MCLK) disable iff (SYS_RST)
		(ser_q == mme_pkg::MME_S_RX) |-> MONITOR_SERIAL_PIN_OE_N;
	endproperty
	a_break_after_sec: assert property (p_break_after_sec) else $error("Serial driven before security");

	property p_vec_page;
		@(posedge MCLK) disable iff (SYS_RST)
		mon_w |=> (VECTOR_PAGE == mme_pkg::MME_MON_VEC_PAGE);
	endproperty
	a_vec_page: assert property (p_vec_page) else $error("Wrong vector page in monitor");

	property p_warm_forced;
		@(posedge MCLK) disable iff (SYS_RST)
		(rise_w && !POR_PULSE && forced_mem_q && mode_fm_w) |=> mode_fm_w;
	endproperty
	a_warm_forced: assert property (p_warm_forced) else $error("Warm reset left forced mode");
endmodule // mme_entry_ctrl
`default_nettype wire

// ---- testbench/mme_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Host end of the monitor link: pullup, wired-OR line and low-stretch timing
module mme_host_model (
	input wire logic clk, // Bus clock
	input wire logic dev_oe_n, // Device drive, low pulls line
	input wire logic host_low, // Host pulls line low
	output logic line, // Resolved line level
	output logic [15:0] low_len, // Length of last low stretch
	output logic [7:0] low_runs // Completed low stretches
);
	logic [15:0] cnt_q; // Running low count
	// Pullup wins unless some side pulls low
	assign line = ~(~dev_oe_n | host_low);
	// Start from an empty record
	initial begin
		cnt_q = 16'h0000;
		low_len = 16'h0000;
		low_runs = 8'h00;
	end
	// Measure each low stretch in bus clocks, NRZ level per clock
	always @(posedge clk) begin
		if (line) begin
			if (cnt_q != 16'h0000) begin
				low_len <= cnt_q;
				low_runs <= low_runs + 8'h01;
			end
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
endmodule // mme_host_model
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for monitor entry control
module tb;
	logic MCLK, SYS_RST, POR_PULSE, INT_RESET, TEST_HIGH_VOLTAGE, INT_PIN_LEVEL; // Drives
	logic MODE_SELECT_LOW_PIN, MODE_SELECT_HIGH_PIN, RESET_VECTOR_ERASED; // Pins
	logic VEC_FETCH_VALID, INT_PIN_FUNCTION_ENABLE, CFG_ALT_RESET_EN, CFG_ALT_CLOCK_EN; // Config
	logic SEC_BYTE_DONE, PORT_INT_BIT_RAW, host_low; // Firmware, host
	logic [7:0] VEC_FETCH_DATA; // Fetched byte
	logic line, ser_out, ser_oe_n, mon, frc, int_osc, trim, ext_clk, wd_off; // Outputs
	logic alt_rst, alt_clk, pins_in, br_en, port_rd, vec_req, ready; // Outputs
	logic [7:0] page, low_runs; // Vector page, host runs
	logic [15:0] low_len; // Host low stretch
	logic seen; // Vector request seen
	int err_total, tests_run; // Counters
	// Clock at 8 ns
	always #4 MCLK = ~MCLK;
	mme_host_model host (.clk(MCLK), .dev_oe_n(ser_oe_n), .host_low(host_low), .line(line),
		.low_len(low_len), .low_runs(low_runs));
	mme_entry_ctrl uut (.MCLK(MCLK), .SYS_RST(SYS_RST), .POR_PULSE(POR_PULSE),
		.INT_RESET(INT_RESET), .TEST_HIGH_VOLTAGE(TEST_HIGH_VOLTAGE),
		.INT_PIN_LEVEL(INT_PIN_LEVEL), .MODE_SELECT_LOW_PIN(MODE_SELECT_LOW_PIN),
		.MODE_SELECT_HIGH_PIN(MODE_SELECT_HIGH_PIN), .MONITOR_SERIAL_PIN_IN(line),
		.MONITOR_SERIAL_PIN_OUT(ser_out), .MONITOR_SERIAL_PIN_OE_N(ser_oe_n),
		.RESET_VECTOR_ERASED(RESET_VECTOR_ERASED), .VEC_FETCH_VALID(VEC_FETCH_VALID),
		.VEC_FETCH_DATA(VEC_FETCH_DATA), .INT_PIN_FUNCTION_ENABLE(INT_PIN_FUNCTION_ENABLE),
		.CFG_ALT_RESET_EN(CFG_ALT_RESET_EN), .CFG_ALT_CLOCK_EN(CFG_ALT_CLOCK_EN),
		.SEC_BYTE_DONE(SEC_BYTE_DONE), .PORT_INT_BIT_RAW(PORT_INT_BIT_RAW),
		.MONITOR_ACTIVE(mon), .FORCED_MONITOR(frc), .USE_INTERNAL_OSC(int_osc),
		.APPLY_OSC_TRIM(trim), .EXT_CLOCK_SELECT(ext_clk), .WATCHDOG_DISABLE(wd_off),
		.ALT_RESET_PIN_EN(alt_rst), .ALT_CLOCK_IN_PIN_EN(alt_clk), .PINS_FORCE_INPUT(pins_in),
		.BRANCH_INT_ENABLE(br_en), .PORT_INT_BIT_READ(port_rd), .VECTOR_PAGE(page),
		.VECTOR_RESET_REQ(vec_req), .MONITOR_READY(ready));
	// Compare and count
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, got, exp);
		end
	endtask
	// Verdict and stop
	task end_sim;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Wait n falling edges
	task cyc(input int n);
		repeat (n) @(negedge MCLK);
	endtask
	// Synchronous reset for six cycles
	task do_rst;
		SYS_RST = 1'b1;
		cyc(6);
		SYS_RST = 1'b0;
		cyc(2);
	endtask
	// Set pins, optional power-on, then release internal reset
	task entry(input logic por, tv, il, m0, m1, ser, er);
		TEST_HIGH_VOLTAGE = tv;
		INT_PIN_LEVEL = il;
		MODE_SELECT_LOW_PIN = m0;
		MODE_SELECT_HIGH_PIN = m1;
		host_low = ~ser;
		RESET_VECTOR_ERASED = er;
		POR_PULSE = por;
		INT_RESET = 1'b1;
		cyc(4);
		POR_PULSE = 1'b0;
		INT_RESET = 1'b0;
		cyc(5);
	endtask
	// Two back-to-back vector byte fetches, then watch for the request
	task fetch(input logic [7:0] a, input logic [7:0] b);
		seen = 1'b0;
		VEC_FETCH_VALID = 1'b1;
		VEC_FETCH_DATA = a;
		cyc(1);
		VEC_FETCH_DATA = b;
		cyc(1);
		VEC_FETCH_VALID = 1'b0;
		repeat (4) begin
			if (vec_req === 1'b1) seen = 1'b1;
			cyc(1);
		end
	endtask
	// Eight security bytes, then measure the break on the line
	task ser_run(input logic [15:0] bitc);
		logic [7:0] r0;
		r0 = low_runs;
		for (int i = 0; i < 8; i++) begin
			if (i == 7) begin
				cyc(600);
				chk(low_runs - r0, 16'h0000);
			end
			SEC_BYTE_DONE = 1'b1;
			cyc(1);
			SEC_BYTE_DONE = 1'b0;
			cyc(4);
		end
		for (int n = 0; n < 8000 && ready !== 1'b1; n++) cyc(1);
		cyc(2);
		chk(ready, 16'h0001);
		chk(low_len, bitc * 16'h000A);
		chk(low_runs - r0, 16'h0001);
		chk(ser_out, 16'h0000);
	endtask
	// Hang guard
	initial begin
		repeat (60000) @(posedge MCLK);
		err_total++;
		end_sim;
	end
	// Main sequence
	initial begin
		MCLK = 1'b0;
		{POR_PULSE, INT_RESET, TEST_HIGH_VOLTAGE, INT_PIN_LEVEL} = 4'h0;
		{MODE_SELECT_LOW_PIN, MODE_SELECT_HIGH_PIN, RESET_VECTOR_ERASED} = 3'h0;
		{VEC_FETCH_VALID, INT_PIN_FUNCTION_ENABLE, CFG_ALT_RESET_EN, CFG_ALT_CLOCK_EN} = 4'h0;
		{SEC_BYTE_DONE, host_low} = 2'h0;
		PORT_INT_BIT_RAW = 1'b1;
		VEC_FETCH_DATA = 8'h00;
		err_total = 0;
		tests_run = 0;
		do_rst;
		// Normal entry by high voltage
		entry(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
		chk(mon, 16'h0001);
		chk(frc, 16'h0000);
		chk(ext_clk, 16'h0001);
		chk(wd_off, 16'h0001);
		chk({alt_rst, alt_clk}, 16'h0003);
		chk(page, 16'h00FE);
		chk(port_rd, 16'h0000);
		MODE_SELECT_LOW_PIN = 1'b0;
		MODE_SELECT_HIGH_PIN = 1'b1;
		cyc(5);
		chk(mon, 16'h0001);
		TEST_HIGH_VOLTAGE = 1'b0;
		cyc(5);
		chk(mon, 16'h0001);
		chk(alt_rst, 16'h0000);
		chk(br_en, 16'h0000);
		chk(wd_off, 16'h0000);
		CFG_ALT_RESET_EN = 1'b1;
		INT_PIN_FUNCTION_ENABLE = 1'b1;
		cyc(5);
		chk(alt_rst, 16'h0000);
		chk(br_en, 16'h0001);
		// Refused normal entries and the blocked internal option
		INT_PIN_FUNCTION_ENABLE = 1'b0;
		CFG_ALT_RESET_EN = 1'b0;
		entry(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		chk(mon, 16'h0000);
		entry(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		chk(mon, 16'h0000);
		entry(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		chk({mon, int_osc, wd_off}, 16'h0000);
		chk(page, 16'h00FF);
		chk(port_rd, 16'h0001);
		// Vector watch in user mode
		fetch(8'hFF, 8'h34);
		chk(seen, 16'h0000);
		fetch(8'hFF, 8'hFF);
		chk(seen, 16'h0001);
		// Warm re-entry into forced monitor, external clock
		entry(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
		chk({mon, frc}, 16'h0003);
		chk({ext_clk, int_osc}, 16'h0002);
		chk(wd_off, 16'h0001);
		chk({pins_in, alt_clk}, 16'h0003);
		chk(br_en, 16'h0001);
		chk(port_rd, 16'h0000);
		entry(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		chk(frc, 16'h0001);
		chk(int_osc, 16'h0000);
		chk(wd_off, 16'h0001);
		// Forced external clock link
		do_rst;
		entry(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
		ser_run(16'd256);
		// Forced internal oscillator, pin held low all session
		do_rst;
		entry(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		chk({int_osc, trim}, 16'h0003);
		chk(ext_clk, 16'h0000);
		chk({pins_in, alt_clk}, 16'h0002);
		ser_run(16'd335);
		end_sim;
	end
endmodule // tb
`default_nettype wire
